// File: src/ccd_fe_pkg.sv
// Constants shared by the CCD front end digital interface.
package ccd_fe_pkg;

  // ****************************************
  // Data path
  // ****************************************
  localparam int          DATA_W        = 12;
  localparam int          CLK_MHZ       = 20;
  localparam int          CONV_MAX_MHZ  = 28;

  // ****************************************
  // Serial settings word
  // ****************************************
  localparam int          SER_W         = 16;
  localparam int          SER_ADDR_HI   = 15;
  localparam int          SER_ADDR_LO   = 12;
  localparam logic [3:0]  SER_ADDR_GAIN = 4'h0;
  localparam logic [3:0]  SER_ADDR_POL  = 4'h1;
  localparam logic [3:0]  SER_ADDR_DLY  = 4'h2;

  // ****************************************
  // Gain, linear in decibels
  // ****************************************
  localparam int          GAIN_W        = 8;
  localparam int          GAIN_MIN_DB   = -6;
  localparam int          GAIN_MAX_DB   = 42;
  localparam logic [7:0]  GAIN_CODE_MAX = 8'hC0;
  localparam logic [7:0]  GAIN_RESET    = 8'h00;

  // ****************************************
  // Pulse polarity and output delay
  // ****************************************
  localparam int          POL_W         = 4;
  localparam logic [3:0]  POL_RESET     = 4'h0;
  localparam logic [1:0]  DLY_RESET     = 2'h0;
  localparam int          DLY0_NS       = 0;
  localparam int          DLY1_NS       = 5;
  localparam int          DLY2_NS       = 10;
  localparam int          DLY3_NS       = 13;
  localparam int          DLY_MAX_CYC   = 1;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  REG_CONFIG    = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_LAST      = 8'h08;
  localparam logic [7:0]  REG_COUNT     = 8'h0C;
  localparam int          CFG_TP_EN     = 0;
  localparam int          CFG_TP_LO     = 16;
  localparam logic [31:0] CFG_MASK      = 32'h0FFF_0001;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
  localparam int          ST_POL_LO     = 8;
  localparam int          ST_DLY_LO     = 12;
  localparam int          ST_BLANK      = 16;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

endpackage

// File: src/output_delay.sv
// Selectable delay line for conversion words.
`timescale 1ns/10ps
module output_delay
  import ccd_fe_pkg::*;
#(
  parameter int W     = DATA_W,
  parameter int DEPTH = DLY_MAX_CYC
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         valid_i,
  input  wire logic [W-1:0] data_i,
  input  wire logic [1:0]   taps_i,
  output logic              valid_o,
  output logic [W-1:0]      data_o
);

  logic [W-1:0] stage_ff [DEPTH];
  logic         vld_ff   [DEPTH];

  // ****************************************
  // Delay stages
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gen_stage
      if (g == 0) begin : gen_first
        always_ff @(posedge clk_i or negedge rst_n_i) begin
          if (!rst_n_i) begin
            stage_ff[g] <= '0;
            vld_ff[g]   <= 1'b0;
          end else begin
            stage_ff[g] <= data_i;
            vld_ff[g]   <= valid_i;
          end
        end
      end else begin : gen_next
        always_ff @(posedge clk_i or negedge rst_n_i) begin
          if (!rst_n_i) begin
            stage_ff[g] <= '0;
            vld_ff[g]   <= 1'b0;
          end else begin
            stage_ff[g] <= stage_ff[g-1];
            vld_ff[g]   <= vld_ff[g-1];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Tap selection
  // ****************************************
  always_comb begin
    if (taps_i == 2'h0) begin
      valid_o = valid_i;
      data_o  = data_i;
    end else begin
      valid_o = vld_ff[32'(taps_i) - 1];
      data_o  = stage_ff[32'(taps_i) - 1];
    end
  end

endmodule

// File: src/ccd_frontend_digital_interface.sv
// Digital side of the CCD front end: serial settings, pulse polarity, output word and AHB-Lite registers.
//
// How it works
// (R1) Each result leaves as a 12-bit word, bit 0 least, bit 11 most significant.
// (R2) The output buffer updates from conversion clock rising edges, which also pace conversions.
// (R3) One output word per conversion clock period, rates up to 28 MHz; here CLK_I at 20 MHz samples that clock, so at most 10 MHz.
// (R4) Blanking input low forces every output bit to zero; high is normal operation.
// (R5) Reset low resets the whole block at once, without a clock edge.
// (R6) One serial data bit shifts in on each shift clock rising edge.
// (R7) Latch strobe rising edge moves the shifted word into the internal settings.
// (R8) Optical black clamp input is active low unless its polarity bit is set.
// (R9) Reference level sampling input is active low by default.
// (R10) Video level sampling input is active low by default.
// (R11) Dummy pixel clamp input is active low by default.
// (R12) Gain code sets -6 dB to 42 dB in steps linear in decibels.
// (R13) Two-bit field adds 0, 5, 10 or 13 ns of output data delay; here codes 1 to 3 all add one CLK_I cycle.
// (R14) Settings stay unchanged while bits shift in, until the latch strobe edge.
// (R15) Reset restores all serial settings to defaults, polarity active low.
`timescale 1ns/10ps
module ccd_frontend_digital_interface
  import ccd_fe_pkg::*;
#(
  parameter int          DATA_WIDTH = DATA_W,
  parameter logic [7:0]  GAIN_MAX   = GAIN_CODE_MAX
) (
  input  wire logic                  CLK_I,
  input  wire logic                  RSTN_I,
  input  wire logic                  CONVERSION_CLOCK_I,
  input  wire logic [DATA_WIDTH-1:0] ADC_RESULT_I,
  input  wire logic                  OUTPUT_BLANK_N_I,
  input  wire logic                  OPTICAL_BLACK_CLAMP_PULSE_I,
  input  wire logic                  REFERENCE_SAMPLE_PULSE_I,
  input  wire logic                  VIDEO_SAMPLE_PULSE_I,
  input  wire logic                  DUMMY_PIXEL_CLAMP_PULSE_I,
  input  wire logic                  SERIAL_SHIFT_CLOCK_I,
  input  wire logic                  SERIAL_DATA_IN_I,
  input  wire logic                  SERIAL_LATCH_STROBE_I,
  input  wire logic                  HSEL_I,
  input  wire logic [31:0]           HADDR_I,
  input  wire logic [1:0]            HTRANS_I,
  input  wire logic                  HWRITE_I,
  input  wire logic [2:0]            HSIZE_I,
  input  wire logic [31:0]           HWDATA_I,
  input  wire logic                  HREADY_I,
  output logic      [31:0]           HRDATA_O,
  output logic                       HREADYOUT_O,
  output logic                       HRESP_O,
  output logic      [DATA_WIDTH-1:0] DATA_O,
  output logic                       DATA_VALID_O,
  output logic                       OB_CLAMP_O,
  output logic                       REF_SAMPLE_O,
  output logic                       VIDEO_SAMPLE_O,
  output logic                       DUMMY_CLAMP_O,
  output logic      [GAIN_W-1:0]     GAIN_CODE_O
);

  // ****************************************
  // Delay figures in cycles of CLK_I
  // ****************************************
  localparam int         DLY1_CYC = (DLY1_NS * CLK_MHZ + 999) / 1000;
  localparam int         DLY2_CYC = (DLY2_NS * CLK_MHZ + 999) / 1000;
  localparam int         DLY3_CYC = (DLY3_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] TAP0     = 2'(DLY0_NS);
  localparam logic [1:0] TAP1     = 2'((DLY1_CYC < 1) ? 1 : DLY1_CYC);
  localparam logic [1:0] TAP2     = 2'((DLY2_CYC < 1) ? 1 : DLY2_CYC);
  localparam logic [1:0] TAP3     = 2'((DLY3_CYC < 1) ? 1 : DLY3_CYC);

  logic                  conv_prev_ff;
  logic                  sclk_prev_ff;
  logic                  serial_latch_strobe_prev_ff;
  logic                  conv_rise;
  logic                  sclk_rise;
  logic                  serial_latch_strobe_rise;
  logic [SER_W-1:0]      shift_ff;
  logic [3:0]            ser_addr;
  logic [GAIN_W-1:0]     gain_ff;
  logic [POL_W-1:0]      pol_ff;
  logic [1:0]            dly_sel_ff;
  logic [1:0]            taps;
  logic [DATA_WIDTH-1:0] capt_ff;
  logic                  capt_vld_ff;
  logic                  dly_vld;
  logic [DATA_WIDTH-1:0] dly_data;
  logic [DATA_WIDTH-1:0] data_out_ff;
  logic                  data_vld_ff;
  logic                  ob_ff;
  logic                  ref_ff;
  logic                  vid_ff;
  logic                  dum_ff;
  logic [31:0]           count_ff;
  logic [31:0]           config_ff;
  logic [31:0]           nxt_config_ff;
  logic                  ahb_wr_ff;
  logic [7:0]            ahb_addr_ff;
  logic                  ahb_take;
  logic [31:0]           rd_value;
  logic [31:0]           hrdata_ff;
  logic                  hreadyout_ff;

  // ****************************************
  // Edge detection of sampled inputs
  // ****************************************
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin // (R5)
      conv_prev_ff  <= 1'b0;
      sclk_prev_ff  <= 1'b0;
      serial_latch_strobe_prev_ff <= 1'b0;
    end else begin
      conv_prev_ff  <= CONVERSION_CLOCK_I;
      sclk_prev_ff  <= SERIAL_SHIFT_CLOCK_I;
      serial_latch_strobe_prev_ff <= SERIAL_LATCH_STROBE_I;
    end
  end

  assign conv_rise  = CONVERSION_CLOCK_I & ~conv_prev_ff;
  assign sclk_rise  = SERIAL_SHIFT_CLOCK_I & ~sclk_prev_ff;
  assign serial_latch_strobe_rise = SERIAL_LATCH_STROBE_I & ~serial_latch_strobe_prev_ff;

  // ****************************************
  // Serial shift register
  // ****************************************
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      shift_ff <= '0;
    end else if (sclk_rise) begin
      shift_ff <= {shift_ff[SER_W-2:0], SERIAL_DATA_IN_I}; // (R6)
    end
  end

  assign ser_addr = shift_ff[SER_ADDR_HI:SER_ADDR_LO];

  // ****************************************
  // Settings loaded by the latch strobe
  // ****************************************
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      gain_ff    <= GAIN_RESET; // (R15)
      pol_ff     <= POL_RESET; // (R15)
      dly_sel_ff <= DLY_RESET; // (R15)
    end else if (serial_latch_strobe_rise) begin // (R7)
      unique case (ser_addr)
        SER_ADDR_GAIN: begin
          // Gain in dB is GAIN_MIN_DB plus a fixed step per code up to GAIN_MAX_DB.
          if (shift_ff[GAIN_W-1:0] > GAIN_MAX) begin // (R12)
            gain_ff <= GAIN_MAX;
          end else begin
            gain_ff <= shift_ff[GAIN_W-1:0]; // (R12)
          end
        end
        SER_ADDR_POL: begin
          pol_ff <= shift_ff[POL_W-1:0];
        end
        SER_ADDR_DLY: begin
          dly_sel_ff <= shift_ff[1:0]; // (R13)
        end
        default: begin
          gain_ff <= gain_ff; // (R14)
        end
      endcase
    end
  end

  // ****************************************
  // Timing pulse polarity
  // ****************************************
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ob_ff  <= 1'b0;
      ref_ff <= 1'b0;
      vid_ff <= 1'b0;
      dum_ff <= 1'b0;
    end else begin
      ob_ff  <= OPTICAL_BLACK_CLAMP_PULSE_I ~^ pol_ff[0]; // (R8)
      ref_ff <= REFERENCE_SAMPLE_PULSE_I ~^ pol_ff[1]; // (R9)
      vid_ff <= VIDEO_SAMPLE_PULSE_I ~^ pol_ff[2]; // (R10)
      dum_ff <= DUMMY_PIXEL_CLAMP_PULSE_I ~^ pol_ff[3]; // (R11)
    end
  end

  // ****************************************
  // Conversion capture
  // ****************************************
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      capt_ff     <= '0;
      capt_vld_ff <= 1'b0;
    end else begin
      capt_vld_ff <= conv_rise; // (R3)
      if (conv_rise) begin // (R2)
        if (config_ff[CFG_TP_EN]) begin
          capt_ff <= config_ff[CFG_TP_LO +: DATA_WIDTH];
        end else begin
          capt_ff <= ADC_RESULT_I;
        end
      end
    end
  end

  always_comb begin
    unique case (dly_sel_ff)
      2'h0: taps = TAP0; // (R13)
      2'h1: taps = TAP1; // (R13)
      2'h2: taps = TAP2; // (R13)
      2'h3: taps = TAP3; // (R13)
    endcase
  end

  output_delay #(
    .W     (DATA_WIDTH),
    .DEPTH (DLY_MAX_CYC)
  ) i_output_delay (
    .clk_i   (CLK_I),
    .rst_n_i (RSTN_I),
    .valid_i (capt_vld_ff),
    .data_i  (capt_ff),
    .taps_i  (taps),
    .valid_o (dly_vld),
    .data_o  (dly_data)
  );

  // ****************************************
  // Output buffer with blanking
  // ****************************************
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      data_out_ff <= '0;
      data_vld_ff <= 1'b0;
    end else begin
      data_vld_ff <= dly_vld;
      if (!OUTPUT_BLANK_N_I) begin
        data_out_ff <= '0; // (R4)
      end else if (dly_vld) begin
        data_out_ff <= dly_data; // (R1)
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      count_ff <= '0;
    end else if (dly_vld) begin
      count_ff <= count_ff + 32'h0000_0001;
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign ahb_take = HSEL_I & HREADY_I & (HTRANS_I == HTRANS_NONSEQ);

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ahb_wr_ff   <= 1'b0;
      ahb_addr_ff <= '0;
    end else if (HREADY_I) begin
      ahb_wr_ff   <= ahb_take & HWRITE_I & (HADDR_I[31:8] == 24'h00_0000);
      ahb_addr_ff <= HADDR_I[7:0];
    end
  end

  always_comb begin
    nxt_config_ff = config_ff;
    if (ahb_wr_ff && (ahb_addr_ff == REG_CONFIG)) begin
      nxt_config_ff = HWDATA_I & CFG_MASK;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      config_ff <= CFG_RESET;
    end else begin
      config_ff <= nxt_config_ff;
    end
  end

  always_comb begin
    rd_value = '0;
    if (HADDR_I[31:8] == 24'h00_0000) begin
      unique case (HADDR_I[7:0])
        REG_CONFIG: rd_value = nxt_config_ff;
        REG_STATUS: begin
          rd_value[GAIN_W-1:0]            = gain_ff;
          rd_value[ST_POL_LO +: POL_W]    = pol_ff;
          rd_value[ST_DLY_LO +: 2]        = dly_sel_ff;
          rd_value[ST_BLANK]              = OUTPUT_BLANK_N_I;
        end
        REG_LAST:   rd_value[DATA_WIDTH-1:0] = data_out_ff;
        REG_COUNT:  rd_value = count_ff;
        default:    rd_value = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      hrdata_ff    <= '0;
      hreadyout_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      if (ahb_take && !HWRITE_I) begin
        hrdata_ff <= rd_value;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign HRDATA_O       = hrdata_ff;
  assign HREADYOUT_O    = hreadyout_ff;
  assign HRESP_O        = 1'b0;
  assign DATA_O         = data_out_ff;
  assign DATA_VALID_O   = data_vld_ff;
  assign OB_CLAMP_O     = ob_ff;
  assign REF_SAMPLE_O   = ref_ff;
  assign VIDEO_SAMPLE_O = vid_ff;
  assign DUMMY_CLAMP_O  = dum_ff;
  assign GAIN_CODE_O    = gain_ff;

endmodule

// File: testbench/ccd_fe_assertions.sv
// Concurrent checks on the front end ports.
`timescale 1ns/10ps
module ccd_fe_checker
  import ccd_fe_pkg::*;
#(
  parameter int         DATA_WIDTH = DATA_W,
  parameter logic [7:0] GAIN_MAX   = GAIN_CODE_MAX
) (
  input wire logic                  CLK_I,
  input wire logic                  RSTN_I,
  input wire logic                  CONVERSION_CLOCK_I,
  input wire logic                  OUTPUT_BLANK_N_I,
  input wire logic                  SERIAL_LATCH_STROBE_I,
  input wire logic                  HREADYOUT_O,
  input wire logic [DATA_WIDTH-1:0] DATA_O,
  input wire logic                  DATA_VALID_O,
  input wire logic [GAIN_W-1:0]     GAIN_CODE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // ****************************************
  // Assertions
  // ****************************************
  sequence conv_rise;
    CONVERSION_CLOCK_I && !$past(CONVERSION_CLOCK_I);
  endsequence
  sequence word_out;
    ##[2:3] DATA_VALID_O;
  endsequence
  a_word_after_conv: assert property (conv_rise |-> word_out)
    else $error("no word after conversion clock");
  a_no_spurious: assert property (DATA_VALID_O |-> ($past(CONVERSION_CLOCK_I, 2) && !$past(CONVERSION_CLOCK_I, 3))
    || ($past(CONVERSION_CLOCK_I, 3) && !$past(CONVERSION_CLOCK_I, 4)))
    else $error("word without conversion clock");
  a_valid_single: assert property (DATA_VALID_O |=> !DATA_VALID_O)
    else $error("valid longer than one cycle");
  a_blank_zero: assert property (!OUTPUT_BLANK_N_I |=> DATA_O == '0)
    else $error("output not zero while blanked");
  a_data_steady: assert property (!DATA_VALID_O && OUTPUT_BLANK_N_I && $past(OUTPUT_BLANK_N_I) |-> $stable(DATA_O))
    else $error("output changed without a word");
  a_ready_always: assert property (1'b1 |=> HREADYOUT_O)
    else $error("bus not ready after reset");
  a_gain_limit: assert property (GAIN_CODE_O <= GAIN_MAX)
    else $error("gain above range");
  a_gain_latch: assert property ($changed(GAIN_CODE_O)
    |-> $past(SERIAL_LATCH_STROBE_I) && !$past(SERIAL_LATCH_STROBE_I, 2))
    else $error("gain changed without strobe");
endmodule

// File: testbench/ccd_fe_serial_host.sv
// Serial settings host that shifts one word and strobes it in.
`timescale 1ns/10ps
module ccd_fe_serial_host
  import ccd_fe_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        go_i,
  input  wire logic [15:0] word_i,
  output logic             sck_o,
  output logic             sdat_o,
  output logic             serial_latch_strobe_o,
  output logic             busy_o
);
  initial begin
    sck_o = 1'b0;
    sdat_o = 1'b0;
    serial_latch_strobe_o = 1'b0;
    busy_o = 1'b0;
  end
  // Data moves right after each sampled shift edge, and is inverted once held no longer.
  always @(posedge clk_i) begin
    if (rst_n_i && go_i && !busy_o) begin
      busy_o <= 1'b1;
      sdat_o <= word_i[SER_W-1];
      for (int i = SER_W - 1; i >= 0; i--) begin
        @(posedge clk_i);
        sck_o <= 1'b1;
        @(posedge clk_i);
        sck_o <= 1'b0;
        sdat_o <= (i > 0) ? word_i[i-1] : ~word_i[0];
      end
      @(posedge clk_i);
      serial_latch_strobe_o <= 1'b1;
      @(posedge clk_i);
      serial_latch_strobe_o <= 1'b0;
      busy_o <= 1'b0;
    end
  end
endmodule

// File: testbench/ccd_frontend_digital_interface_tb_top.sv
// Self-checking bench for the CCD front end digital interface.
`timescale 1ns/10ps
module ccd_frontend_digital_interface_tb_top;
  import ccd_fe_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cclk = 1'b0;
  logic [11:0] adc = 12'h000;
  logic        blank_n = 1'b1;
  logic [3:0]  pin = 4'hF;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        go = 1'b0;
  logic [15:0] sword = 16'h0;
  logic        sck, sdat, serial_latch_strobe, busy, hready, dvalid, hresp;
  logic [31:0] hrdata, rd;
  logic [11:0] dout;
  logic [3:0]  pout;
  logic [7:0]  gain;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;

  ccd_frontend_digital_interface i_ccd_frontend_digital_interface (
    .CLK_I(clk), .RSTN_I(rst_n), .CONVERSION_CLOCK_I(cclk), .ADC_RESULT_I(adc), .OUTPUT_BLANK_N_I(blank_n),
    .OPTICAL_BLACK_CLAMP_PULSE_I(pin[0]), .REFERENCE_SAMPLE_PULSE_I(pin[1]), .VIDEO_SAMPLE_PULSE_I(pin[2]),
    .DUMMY_PIXEL_CLAMP_PULSE_I(pin[3]), .SERIAL_SHIFT_CLOCK_I(sck), .SERIAL_DATA_IN_I(sdat),
    .SERIAL_LATCH_STROBE_I(serial_latch_strobe), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .DATA_O(dout), .DATA_VALID_O(dvalid), .OB_CLAMP_O(pout[0]), .REF_SAMPLE_O(pout[1]),
    .VIDEO_SAMPLE_O(pout[2]), .DUMMY_CLAMP_O(pout[3]), .GAIN_CODE_O(gain));
  ccd_fe_serial_host i_ccd_fe_serial_host (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .word_i(sword),
    .sck_o(sck), .sdat_o(sdat), .serial_latch_strobe_o(serial_latch_strobe), .busy_o(busy));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(hresp, 1'b0);
  endtask
  task automatic conv(input logic [11:0] d, input int lat, input logic [11:0] exp);
    adc <= d;
    cclk <= 1'b1;
    @(posedge clk);
    cclk <= 1'b0;
    repeat (lat - 1) @(posedge clk);
    #1;
    chk(dvalid, 1'b1);
    chk(dout, exp);
    @(posedge clk);
  endtask
  task automatic pulses(input logic [3:0] pol);
    logic [3:0] e;
    for (int i = 0; i < 5; i++) begin
      pin <= 4'h1 << i;
      e = ~((4'h1 << i) ^ pol);
      @(posedge clk);
      #1;
      chk(pout, e);
      @(posedge clk);
    end
    pin <= ~pol;
    @(posedge clk);
  endtask
  task automatic ser(input logic [15:0] w, input logic [7:0] gmid, input logic [7:0] gend);
    sword <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk(gain, gmid);
    @(posedge clk);
    while (busy === 1'b1) @(posedge clk);
    @(posedge clk);
    #1;
    chk(gain, gend);
    @(posedge clk);
  endtask
  task automatic tdone(input string n);
    $display("test %s done", n);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdchk(REG_CONFIG, CFG_RESET);
    rdchk(REG_STATUS, 32'h0001_0000);
    rdchk(REG_COUNT, 32'h0);
    chk(gain, GAIN_RESET);
    tdone("reset");
    conv(12'hA5C, 2, 12'hA5C);
    conv(12'h801, 2, 12'h801);
    rdchk(REG_LAST, 32'h801);
    rdchk(REG_COUNT, 32'h2);
    tdone("data");
    blank_n <= 1'b0;
    conv(12'hFFF, 2, 12'h000);
    rdchk(REG_STATUS, 32'h0);
    blank_n <= 1'b1;
    @(posedge clk);
    tdone("blank");
    pulses(4'h0);
    ser({SER_ADDR_GAIN, 12'h080}, 8'h00, 8'h80);
    ser({SER_ADDR_GAIN, 12'h0FF}, 8'h80, GAIN_CODE_MAX);
    ser(16'h7055, GAIN_CODE_MAX, GAIN_CODE_MAX);
    ser({SER_ADDR_POL, 12'h00F}, GAIN_CODE_MAX, GAIN_CODE_MAX);
    pulses(4'hF);
    for (int c = 0; c < 4; c++) begin
      ser({SER_ADDR_DLY, 10'h0, c[1:0]}, GAIN_CODE_MAX, GAIN_CODE_MAX);
      conv(12'h3C3, (c == 0) ? 2 : 3, 12'h3C3);
    end
    rdchk(REG_STATUS, 32'h0001_3FC0);
    tdone("serial");
    ahb(1'b1, REG_CONFIG, 32'hFFFF_FFFF);
    rdchk(REG_CONFIG, CFG_MASK);
    ahb(1'b1, REG_STATUS, 32'h0);
    rdchk(REG_STATUS, 32'h0001_3FC0);
    ahb(1'b1, 32'h40, 32'hFFFF_FFFF);
    rdchk(32'h40, 32'h0);
    ahb(1'b1, REG_CONFIG, 32'h0ABC_0001);
    conv(12'h123, 3, 12'hABC);
    ahb(1'b1, REG_CONFIG, 32'h0);
    tdone("registers");
    #10;
    rst_n = 1'b0;
    #1;
    chk(gain, 8'h00);
    chk(hready, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdchk(REG_STATUS, 32'h0001_0000);
    pulses(4'h0);
    tdone("second reset");
    finish_test();
  end
endmodule

bind ccd_frontend_digital_interface ccd_fe_checker #(.DATA_WIDTH(DATA_WIDTH), .GAIN_MAX(GAIN_MAX)) i_ccd_fe_checker (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .CONVERSION_CLOCK_I(CONVERSION_CLOCK_I), .OUTPUT_BLANK_N_I(OUTPUT_BLANK_N_I),
  .SERIAL_LATCH_STROBE_I(SERIAL_LATCH_STROBE_I), .HREADYOUT_O(HREADYOUT_O), .DATA_O(DATA_O),
  .DATA_VALID_O(DATA_VALID_O), .GAIN_CODE_O(GAIN_CODE_O));
